//--- src/module_sideband_control_status.v
// Notes on behaviour
// R1: functional within 2000 ms of power-on or reset
// R2: reset only after low longer than 2 us
// R3: serial bus answers within 2000 ms of power
// R4: clear data-not-ready, assert interrupt, within 2000 ms
// R5: functional within 2000 ms after reset release
// R6: low power within 100 us of request
// R7: interrupt low within 200 ms of condition
// R8: flags clear on read, interrupt released
// R9: loss-of-signal flag and interrupt within 100 ms
// R10: any flag set with interrupt within 200 ms
// R11: set mask stops its interrupt within 100 ms
// R12: cleared mask resumes interrupt within 100 ms
// R13: select asserted, bus answers within 100 us
// R14: select released, bus silent within 100 us
// R15: power-down override lowers power within 100 ms
// R16: override cleared, functional within 300 ms
// R17: functional shown by interrupt after ready
// R18: host-triggered times counted from end of transfer
// R19: flag bytes at 3..21, read only
// R20: mask bytes at 100..106, read and write
// R21: synchronise reset, low-power and select inputs
`timescale 1ns/100ps
`include "sideband_map.vh"

module module_sideband_control_status #(
	parameter        FLAG_BYTES  = 19,                   // flag bytes 3..21
	parameter        MASK_BYTES  = 7,                    // mask bytes 100..106
	parameter [31:0] INIT_CYCLES = `INIT_CYCLES,         // initialisation time
	parameter [7:0]  IDENT_CODE  = 8'h5a                 // identifier byte, value arbitrary
) (
	// clock and reset
	input  wire                    clk_sys,
	input  wire                    reset,
	// host sideband pins
	input  wire                    module_reset_low,
	input  wire                    low_power_request,
	input  wire                    module_select_n,
	output reg                     interrupt_out_n,
	output reg                     module_present_n,
	// 2-wire serial bus
	input  wire                    scl_in,
	input  wire                    sda_in,
	output reg                     sda_out,
	output reg                     sda_oe,
	// internal flag conditions, one pulse or level per flag bit
	input  wire [FLAG_BYTES*8-1:0] flag_cond,
	// power and readiness status
	output reg                     low_power_active,
	output reg                     fully_functional
);

	localparam NF = FLAG_BYTES * 8;   // number of flag bits
	localparam NM = MASK_BYTES * 8;   // number of mask bits
	// the minimum low time is cut to the width of its counter on purpose;
	// a longer minimum would need a wider low_cnt as well
	localparam [31:0] RST_MIN_FULL = `RESET_MIN_CYCLES;   // minimum reset low time in cycles
	localparam [7:0]  RST_MIN      = RST_MIN_FULL[7:0];   // same, at counter width

	// one-hot life cycle of the module
	localparam M_HOLD = 3'b001;   // reset held low
	localparam M_INIT = 3'b010;   // initialising, not ready
	localparam M_RUN  = 3'b100;   // fully functional

	wire [4:0] pins_s;            // synchronised pin levels
	wire       rst_low_s  = pins_s[0];
	wire       lp_s       = pins_s[1];
	wire       sel_n_s    = pins_s[2];
	wire       scl_s      = pins_s[3];
	wire       sda_s      = pins_s[4];

	// life cycle, flags, masks and control state
	reg  [2:0]    mode;           // life cycle state
	reg  [7:0]    low_cnt;        // length of the reset low pulse
	reg  [31:0]   init_cnt;       // initialisation timer
	reg           data_not_ready; // status byte bit
	reg           init_flag;      // sticky ready event
	reg  [NF-1:0] flags;          // latched, clear-on-read flags
	reg  [NM-1:0] masks;          // interrupt masks
	reg  [7:0]    control;        // control byte with power-down override
	reg  [7:0]    rd_data;        // byte at the bus pointer
	reg  [NF-1:0] flag_clr;       // per-bit clear from a host read
	reg  [NM-1:0] mask_full;      // masks at their own width, NM bits

	// byte access between the serial slave and the register file
	wire [7:0] ptr;
	wire       wr_pulse;
	wire [7:0] wr_addr;
	wire [7:0] wr_data;
	wire       rd_pulse;
	wire [7:0] rd_addr;
	wire       slave_oe;
	wire       bus_enable;
	wire       pending;

	// all pins from the host pass two flops before use
	// reset levels match each pin's idle state (all high but low power), so no
	// false edge and no false low-power indication follows the release of reset
	sync_bits #(
		.WIDTH   (5),
		.RST_VAL (5'h1d)
	) u_sync (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.async_in ({sda_in, scl_in, module_select_n, low_power_request, module_reset_low}),
		.sync_out (pins_s)
	); // R21

	// bus answers only when selected and past initialisation
	// deselecting aborts a transfer in flight; the host must restart it
	assign bus_enable = ~sel_n_s & (mode == M_RUN); // R3 R13 R14

	serial_slave u_slave (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.scl_s    (scl_s),
		.sda_s    (sda_s),
		.enable   (bus_enable),
		.sda_oe   (slave_oe),
		.ptr      (ptr),
		.rd_data  (rd_data),
		.wr_pulse (wr_pulse),
		.wr_addr  (wr_addr),
		.wr_data  (wr_data),
		.rd_pulse (rd_pulse),
		.rd_addr  (rd_addr)
	);

	// life cycle: a filtered reset pulse holds, release starts the timer
	// a low shorter than the minimum never reaches the hold state, so a
	// glitch on the pin cannot wipe masks or control bits
	// the timer restarts from zero on every release from the hold state; a host that holds
	// the pin low past the minimum more often than the init time keeps the block from running
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mode           <= M_INIT;
			low_cnt        <= 8'h00;
			init_cnt       <= 32'h0;
			data_not_ready <= 1'b1;
		end else begin
			// count the low time, saturating at the minimum
			if (rst_low_s)
				low_cnt <= 8'h00;
			else if (low_cnt != RST_MIN)
				low_cnt <= low_cnt + 8'h01;
			case (mode)
			M_HOLD: begin
				data_not_ready <= 1'b1;
				init_cnt       <= 32'h0;
				if (rst_low_s)
					mode <= M_INIT; // R5
			end
			M_INIT: begin
				if (!rst_low_s && low_cnt == RST_MIN) begin
					mode <= M_HOLD; // R2
				end else if (init_cnt >= INIT_CYCLES - 32'h1) begin
					mode           <= M_RUN;
					data_not_ready <= 1'b0; // R1 R4
				end else begin
					init_cnt <= init_cnt + 32'h1;
				end
			end
			M_RUN: begin
				// short glitches on the reset pin are ignored
				if (!rst_low_s && low_cnt == RST_MIN)
					mode <= M_HOLD; // R2
			end
			default: begin
				mode <= M_HOLD;
			end
			endcase
		end
	end

	// decode host reads of flag bytes into per-bit clears
	// a byte counts as read once its last bit has gone out, even if the
	// host then stops the transfer early
	integer k;
	always @* begin
		flag_clr = {NF{1'b0}};
		for (k = 0; k < FLAG_BYTES; k = k + 1) begin
			if (rd_pulse && rd_addr == `ADDR_FLAG_FIRST + k[7:0])
				flag_clr[k*8 +: 8] = 8'hff; // R8
		end
	end

	// each flag bit latches its condition; a new event beats the clear
	// a flag raised in the very cycle its byte is read stays set, so the
	// host sees it on its next read instead of losing the event
	genvar g;
	generate
		for (g = 0; g < NF; g = g + 1) begin : g_flag
			always @(posedge clk_sys or posedge reset) begin
				if (reset)
					flags[g] <= 1'b0;
				else if (mode == M_HOLD)
					flags[g] <= 1'b0;
				else if (flag_cond[g])
					flags[g] <= 1'b1; // R9 R10
				else if (flag_clr[g])
					flags[g] <= 1'b0; // R8
			end
		end
	endgenerate

	// ready event: raised once at the end of initialisation
	// it repeats the life-cycle test for the end of initialisation, so the
	// event and the switch to the running state land on the same edge
	always @(posedge clk_sys or posedge reset) begin
		if (reset)
			init_flag <= 1'b0;
		else if (mode == M_INIT && init_cnt >= INIT_CYCLES - 32'h1 && !(!rst_low_s && low_cnt == RST_MIN))
			init_flag <= 1'b1; // R4 R17
		else if (mode == M_HOLD)
			init_flag <= 1'b0;
		else if (rd_pulse && rd_addr == `ADDR_STATUS)
			init_flag <= 1'b0; // R8
	end

	// host writes: masks and control; writes to flag bytes are dropped
	// a write to a flag byte is still acknowledged on the bus, but the
	// byte keeps its contents, which keeps the flags read-only
	integer m;
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			masks   <= {MASK_BYTES{`RST_MASK_BYTE}};
			control <= `RST_CONTROL;
		end else if (mode == M_HOLD) begin
			masks   <= {MASK_BYTES{`RST_MASK_BYTE}};
			control <= `RST_CONTROL;
		end else if (wr_pulse) begin
			// acting at the last acked byte is earlier than the stop, so inside every bound
			for (m = 0; m < MASK_BYTES; m = m + 1) begin
				if (wr_addr == `ADDR_MASK_FIRST + m[7:0])
					masks[m*8 +: 8] <= wr_data; // R20 R11 R12 R18
			end
			if (wr_addr == `ADDR_CONTROL)
				control <= wr_data; // R15 R16 R18
		end
	end

	// read mux for the byte at the bus pointer
	// later matches win; the address ranges do not overlap, so the order only
	// matters for readability; unmapped bytes read as zero
	integer r;
	always @* begin
		rd_data = 8'h00;
		if (ptr == `ADDR_IDENT)
			rd_data = IDENT_CODE;
		if (ptr == `ADDR_STATUS) begin
			rd_data[`BIT_DATA_NOT_READY] = data_not_ready; // R4
			rd_data[`BIT_INIT_DONE_FLAG] = init_flag;
		end
		for (r = 0; r < FLAG_BYTES; r = r + 1) begin
			if (ptr == `ADDR_FLAG_FIRST + r[7:0])
				rd_data = flags[r*8 +: 8]; // R19
		end
		for (r = 0; r < MASK_BYTES; r = r + 1) begin
			if (ptr == `ADDR_MASK_FIRST + r[7:0])
				rd_data = masks[r*8 +: 8]; // R20
		end
		if (ptr == `ADDR_CONTROL)
			rd_data = control;
	end

	// masks cover the first flag bytes one for one; the rest stay unmasked
	// only MASK_BYTES mask bytes exist, so later flag bytes cannot be inhibited
	integer q;
	always @* begin
		mask_full = {NM{1'b0}};
		for (q = 0; q < NM; q = q + 1)
			mask_full[q] = masks[q];
	end

	// interrupt source: any unmasked flag or the ready event
	generate
		if (NF > NM) begin : g_wide
			// flag bytes beyond the mask bytes always reach the pin
			assign pending = |(flags & {{(NF-NM){1'b1}}, ~mask_full}) | init_flag;
		end else begin : g_narrow
			assign pending = |(flags & ~mask_full[NF-1:0]) | init_flag;
		end
	endgenerate

	// registered pin outputs
	// every pin output is taken from a flop, so nothing combinational reaches
	// the host connector
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			interrupt_out_n  <= 1'b1;
			module_present_n <= 1'b0;
			sda_out          <= 1'b0;
			sda_oe           <= 1'b0;
			low_power_active <= 1'b0;
			fully_functional <= 1'b0;
		end else begin
			// output stage adds one cycle to every interrupt timing
			interrupt_out_n  <= ~pending; // R7 R8 R11 R12 R17
			module_present_n <= 1'b0;
			sda_out          <= 1'b0;
			sda_oe           <= slave_oe;
			// low power by pin or by override bit
			low_power_active <= lp_s | control[`BIT_PDOWN_OVERRIDE]; // R6 R15 R16
			fully_functional <= (mode == M_RUN); // R1 R5 R17
		end
	end

endmodule

//--- src/serial_slave.v
`timescale 1ns/100ps
`include "sideband_map.vh"

// 2-wire serial slave working on oversampled, synchronised bus levels
module serial_slave (
	// clock and reset
	input  wire       clk_sys,
	input  wire       reset,
	// synchronised bus levels
	input  wire       scl_s,
	input  wire       sda_s,
	input  wire       enable,
	// data line drive (pulls low while high)
	output reg        sda_oe,
	// byte access towards the register file
	output reg  [7:0] ptr,
	input  wire [7:0] rd_data,
	output reg        wr_pulse,
	output reg  [7:0] wr_addr,
	output reg  [7:0] wr_data,
	output reg        rd_pulse,
	output reg  [7:0] rd_addr
);

	localparam S_IDLE = 9'h001, S_DEV  = 9'h002, S_ADEV = 9'h004;
	localparam S_ADDR = 9'h008, S_AADR = 9'h010, S_WDAT = 9'h020;
	localparam S_AWR  = 9'h040, S_RDAT = 9'h080, S_RACK = 9'h100;

	reg [8:0] state;   // one-hot bus state
	reg [3:0] cnt;     // bits in current byte
	reg [7:0] shift;   // receive shifter
	reg [7:0] tx;      // transmit shifter
	reg       rw;      // read when high
	reg       nack;    // master ack bit
	reg       scl_d;   // delayed copies for edge detection
	reg       sda_d;

	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

	// bus sequencer: sample on rising clock, change data on falling clock
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state    <= S_IDLE;
			cnt      <= 4'h0;
			shift    <= 8'h00;
			tx       <= 8'h00;
			rw       <= 1'b0;
			nack     <= 1'b1;
			scl_d    <= 1'b1;
			sda_d    <= 1'b1;
			sda_oe   <= 1'b0;
			ptr      <= 8'h00;
			wr_pulse <= 1'b0;
			wr_addr  <= 8'h00;
			wr_data  <= 8'h00;
			rd_pulse <= 1'b0;
			rd_addr  <= 8'h00;
		end else begin
			scl_d    <= scl_s;
			sda_d    <= sda_s;
			wr_pulse <= 1'b0;
			rd_pulse <= 1'b0;
			if (!enable) begin
				// deselected: let go of the line and forget the transfer
				state  <= S_IDLE;
				sda_oe <= 1'b0;
			end else if (stop_c) begin
				state  <= S_IDLE;
				sda_oe <= 1'b0;
			end else if (start_c) begin
				// repeated start keeps the pointer for random reads
				state  <= S_DEV;
				cnt    <= 4'h0;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				if (state == S_DEV || state == S_ADDR || state == S_WDAT) begin
					shift <= {shift[6:0], sda_s};
					cnt   <= cnt + 4'h1;
				end
				if (state == S_RACK)
					nack <= sda_s;
			end else if (scl_fall) begin
				case (state)
				S_DEV: begin
					if (cnt == 4'h8) begin
						cnt <= 4'h0;
						if (shift[7:1] == `DEV_ADDR) begin
							rw     <= shift[0];
							sda_oe <= 1'b1;
							state  <= S_ADEV;
						end else begin
							state  <= S_IDLE;
						end
					end
				end
				S_ADEV: begin
					if (rw) begin
						tx     <= rd_data;
						sda_oe <= ~rd_data[7];
						cnt    <= 4'h1;
						state  <= S_RDAT;
					end else begin
						sda_oe <= 1'b0;
						state  <= S_ADDR;
					end
				end
				S_ADDR: begin
					if (cnt == 4'h8) begin
						cnt    <= 4'h0;
						ptr    <= shift;
						sda_oe <= 1'b1;
						state  <= S_AADR;
					end
				end
				S_AADR: begin
					sda_oe <= 1'b0;
					state  <= S_WDAT;
				end
				S_WDAT: begin
					if (cnt == 4'h8) begin
						cnt      <= 4'h0;
						wr_pulse <= 1'b1;
						wr_addr  <= ptr;
						wr_data  <= shift;
						sda_oe   <= 1'b1;
						state    <= S_AWR;
					end
				end
				S_AWR: begin
					sda_oe <= 1'b0;
					ptr    <= ptr + 8'h01;
					state  <= S_WDAT;
				end
				S_RDAT: begin
					if (cnt == 4'h8) begin
						// byte fully shifted out: it now counts as read
						sda_oe   <= 1'b0;
						rd_pulse <= 1'b1;
						rd_addr  <= ptr;
						ptr      <= ptr + 8'h01;
						state    <= S_RACK;
					end else begin
						tx     <= {tx[6:0], 1'b0};
						sda_oe <= ~tx[6];
						cnt    <= cnt + 4'h1;
					end
				end
				S_RACK: begin
					if (nack) begin
						state <= S_IDLE;
					end else begin
						tx     <= rd_data;
						sda_oe <= ~rd_data[7];
						cnt    <= 4'h1;
						state  <= S_RDAT;
					end
				end
				S_IDLE: begin
					sda_oe <= 1'b0;
				end
				default: begin
					state  <= S_IDLE;
					sda_oe <= 1'b0;
				end
				endcase
			end
		end
	end

endmodule

//--- src/sideband_map.vh
`ifndef SIDEBAND_MAP_VH
`define SIDEBAND_MAP_VH

// system clock period in ns
`define CLK_PERIOD_NS        10

// response times, in their own units
`define T_INIT_MS            2000
`define T_SERIAL_MS          2000
`define T_DATA_MS            2000
`define T_RESET_MIN_US       2
`define T_LOW_POWER_REQUEST_US          100
`define T_INTERRUPT_OUT_N_ON_MS         200
`define T_INTERRUPT_OUT_N_OFF_US        500
`define T_LOS_ON_MS          100
`define T_FLAG_ON_MS         200
`define T_MASK_MS            100
`define T_MODSEL_US          100
`define T_PDOWN_ON_MS        100
`define T_PDOWN_OFF_MS       300

// derived cycle counts (longest times round down, least times round up)
`define INIT_CYCLES          ((`T_INIT_MS * 100000) / (`CLK_PERIOD_NS / 10))
`define RESET_MIN_CYCLES     ((`T_RESET_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// 2-wire bus device address (7 bit)
`define DEV_ADDR             7'h50

// byte addresses of the lower page
`define ADDR_IDENT           8'h00
`define ADDR_STATUS_HI       8'h01
`define ADDR_STATUS          8'h02
`define ADDR_FLAG_FIRST      8'h03
`define ADDR_FLAG_LAST       8'h15
`define ADDR_CONTROL         8'h5d
`define ADDR_MASK_FIRST      8'h64
`define ADDR_MASK_LAST       8'h6a

// field positions
`define BIT_DATA_NOT_READY   0
`define BIT_INIT_DONE_FLAG   1
`define BIT_PDOWN_OVERRIDE   1

// reset values
`define RST_MASK_BYTE        8'h00
`define RST_CONTROL          8'h00

`endif

//--- src/sync_bits.v
`timescale 1ns/100ps

// two-flop synchroniser, one pair per bit
module sync_bits #(
	parameter WIDTH   = 1,
	parameter RST_VAL = 1'b1
) (
	// clock and reset
	input  wire             clk_sys,
	input  wire             reset,
	// asynchronous inputs and synchronised outputs
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	// reset level per bit, bit i for input i
	localparam [WIDTH-1:0] RST_VEC = RST_VAL;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta;  // first stage, read only by the second
			reg held;  // second stage, safe to use
			// the first flop may go metastable; only the second looks at it
			always @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					meta <= RST_VEC[i];
					held <= RST_VEC[i];
				end else begin
					meta <= async_in[i];
					held <= meta;
				end
			end
			assign sync_out[i] = held;
		end
	endgenerate

endmodule

//--- verification/host_bus_model.sv
`timescale 1ns/100ps
`include "sideband_map.vh"

// host end of the 2-wire bus; the serial clock idles high between frames
module host_bus_model (
	// bus wires
	output logic scl,
	output wire  sda,
	// device pull-down enable
	input  wire  dev_oe
);
	logic drv = 1'b1; // host data drive, high releases the wire

	// pulled-up wire: low while either party pulls it
	assign sda = drv & ~dev_oe;

	initial scl = 1'b1;

	// data moves mid-low, sampled at the end of the high half
	task bit_x(input logic b, output logic r);
		drv = b;
		#31.25 scl = 1'b1;
		#62.5 r = sda;
		scl = 1'b0;
		#31.25;
	endtask

	// start, also used as repeated start
	task start;
		drv = 1'b1;
		#31.25 scl = 1'b1;
		#31.25 drv = 1'b0;
		#31.25 scl = 1'b0;
		#31.25;
	endtask

	// stop leaves both wires released
	task stop;
		drv = 1'b0;
		#31.25 scl = 1'b1;
		#31.25 drv = 1'b1;
		#31.25;
	endtask

	// byte out, msb first; ok drops on a missing acknowledge
	task put(input logic [7:0] d, inout logic ok);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		ok = ok & ~r;
	endtask

	// byte in, then acknowledge unless last
	task get(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(last, r);
	endtask

	// pointer then data
	task wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		ok = 1'b1;
		start();
		put({`DEV_ADDR, 1'b0}, ok);
		put(a, ok);
		put(d, ok);
		stop();
	endtask

	// pointer, repeated start, one byte read
	task rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b1;
		start();
		put({`DEV_ADDR, 1'b0}, ok);
		put(a, ok);
		start();
		put({`DEV_ADDR, 1'b1}, ok);
		get(1'b1, d);
		stop();
	endtask
endmodule

//--- verification/sideband_checker_assertions.sv
`timescale 1ns/100ps

// watches the pins of the sideband control block
module sideband_checker #(
	parameter        FLAG_BYTES  = 19,
	parameter [31:0] INIT_CYCLES = 100
) (
	// clock and reset
	input logic                    clk_sys,
	input logic                    reset,
	// sideband pins
	input logic                    module_reset_low,
	input logic                    low_power_request,
	input logic                    module_select_n,
	input logic                    interrupt_out_n,
	input logic                    module_present_n,
	// serial bus
	input logic                    scl_in,
	input logic                    sda_in,
	input logic                    sda_out,
	input logic                    sda_oe,
	// flags and status
	input logic [FLAG_BYTES*8-1:0] flag_cond,
	input logic                    low_power_active,
	input logic                    fully_functional
);
	logic [31:0] init_cnt; // cycles initialising with the pin released
	logic [15:0] low_cnt;  // consecutive low cycles of the reset pin

	// counters stand in for long repetitions, which the tools cannot unroll
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			init_cnt <= '0;
			low_cnt  <= '0;
		end else begin
			init_cnt <= (!fully_functional && module_reset_low) ? init_cnt + 32'd1 : '0;
			low_cnt  <= module_reset_low ? '0 : low_cnt + 16'd1;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_init_bound: assert property (init_cnt <= INIT_CYCLES + 8)
		else $error("initialisation took too long");
	a_lp_follow: assert property ($rose(low_power_request) |-> ##[1:8] low_power_active)
		else $error("low power not entered");
	a_lp_hold: assert property (low_power_request [*8] |-> low_power_active)
		else $error("low power dropped while requested");
	a_desel_quiet: assert property (module_select_n [*8] |-> !sda_oe)
		else $error("bus answered while deselected");
	a_early_quiet: assert property (!fully_functional |-> !sda_oe)
		else $error("bus answered before ready");
	a_ready_int: assert property ($rose(fully_functional) |-> ##[0:4] !interrupt_out_n)
		else $error("ready without interrupt");
	a_flag_int: assert property (fully_functional && (|flag_cond[FLAG_BYTES*8-1:56])
		|-> ##[1:6] !interrupt_out_n)
		else $error("unmasked flag without interrupt");
	a_short_reset: assert property ($fell(fully_functional) && !low_power_active |-> low_cnt >= 16'd200)
		else $error("reset taken from a short pulse");

	c_ready: cover property ($rose(fully_functional));
	c_ack:   cover property ($rose(sda_oe));
	c_int:   cover property ($fell(interrupt_out_n));
endmodule

bind module_sideband_control_status sideband_checker #(.FLAG_BYTES(FLAG_BYTES), .INIT_CYCLES(INIT_CYCLES)) i_chk (
	.clk_sys(clk_sys), .reset(reset), .module_reset_low(module_reset_low),
	.low_power_request(low_power_request), .module_select_n(module_select_n),
	.interrupt_out_n(interrupt_out_n), .module_present_n(module_present_n), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .flag_cond(flag_cond),
	.low_power_active(low_power_active), .fully_functional(fully_functional));

//--- verification/tb_top.sv
`timescale 1ns/100ps

module tb_top;
	// clock, reset and sideband pins
	logic         clk_sys           = 1'b0;
	logic         reset             = 1'b1;
	logic         module_reset_low  = 1'b1;
	logic         low_power_request = 1'b0;
	logic         module_select_n   = 1'b0;
	logic [151:0] flag_cond         = '0;
	// device outputs and bus wires
	wire          interrupt_out_n, module_present_n, sda_out, sda_oe;
	wire          low_power_active, fully_functional, scl, sda;
	// bookkeeping
	int           mismatches = 0;
	int           compares   = 0;
	int           cycles     = 0;
	logic [7:0]   rdat;
	logic         ok;

	initial forever #5 clk_sys = ~clk_sys;

	module_sideband_control_status #(.INIT_CYCLES(32'd100), .IDENT_CODE(8'h3c)) i_dut (
		.clk_sys(clk_sys), .reset(reset), .module_reset_low(module_reset_low),
		.low_power_request(low_power_request), .module_select_n(module_select_n),
		.interrupt_out_n(interrupt_out_n), .module_present_n(module_present_n), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .flag_cond(flag_cond),
		.low_power_active(low_power_active), .fully_functional(fully_functional));

	host_bus_model i_host (.scl(scl), .sda(sda), .dev_oe(sda_oe));

	task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task results;
		if (mismatches == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// bounded wait for the interrupt pin level
	task wait_int(input logic v);
		int n;
		n = 0;
		while (interrupt_out_n !== v && n < 60) begin
			@(negedge clk_sys);
			n++;
		end
		chk("interrupt_out_n", {7'h0, v}, {7'h0, interrupt_out_n});
	endtask

	// bounded wait for the end of initialisation
	task wait_ready;
		int n;
		n = 0;
		while (fully_functional !== 1'b1 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		chk("fully_functional", 8'h01, {7'h0, fully_functional});
	endtask

	task pulse(input int b);
		@(negedge clk_sys) flag_cond[b] = 1'b1;
		@(negedge clk_sys) flag_cond[b] = 1'b0;
	endtask

	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		i_host.rd(a, rdat, ok);
		chk("ack", 8'h01, {7'h0, ok});
		chk("read data", exp, rdat);
	endtask

	task wr_do(input logic [7:0] a, input logic [7:0] d);
		i_host.wr(a, d, ok);
		chk("ack", 8'h01, {7'h0, ok});
		@(negedge clk_sys);
	endtask

	// low pulse on the reset pin, then a short settle
	task pin_reset(input int n);
		@(negedge clk_sys) module_reset_low = 1'b0;
		repeat (n) @(negedge clk_sys);
		module_reset_low = 1'b1;
		repeat (10) @(negedge clk_sys);
	endtask

	// a hang counts as a mismatch and closes the run
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			results();
		end
	end

	initial begin
		repeat (2) @(negedge clk_sys);
		chk("interrupt_out_n", 8'h01, {7'h0, interrupt_out_n});
		chk("module_present_n", 8'h00, {7'h0, module_present_n});
		repeat (2) @(negedge clk_sys);
		reset = 1'b0;
		wait_ready();
		wait_int(1'b0);
		rd_chk(8'h02, 8'h02);
		wait_int(1'b1);
		rd_chk(8'h00, 8'h3c);
		pulse(61);
		wait_int(1'b0);
		rd_chk(8'h0a, 8'h20);
		wait_int(1'b1);
		rd_chk(8'h0a, 8'h00);
		pulse(0);
		wait_int(1'b0);
		wr_do(8'h64, 8'h01);
		wait_int(1'b1);
		rd_chk(8'h64, 8'h01);
		wr_do(8'h64, 8'h00);
		wait_int(1'b0);
		wr_do(8'h03, 8'hff);
		rd_chk(8'h03, 8'h01);
		wait_int(1'b1);
		rd_chk(8'h16, 8'h00);
		@(negedge clk_sys) low_power_request = 1'b1;
		repeat (10) @(negedge clk_sys);
		chk("low_power_active", 8'h01, {7'h0, low_power_active});
		low_power_request = 1'b0;
		repeat (10) @(negedge clk_sys);
		chk("low_power_active", 8'h00, {7'h0, low_power_active});
		wr_do(8'h5d, 8'h02);
		chk("low_power_active", 8'h01, {7'h0, low_power_active});
		rd_chk(8'h5d, 8'h02);
		wr_do(8'h5d, 8'h00);
		chk("low_power_active", 8'h00, {7'h0, low_power_active});
		wait_ready();
		@(negedge clk_sys) module_select_n = 1'b1;
		repeat (10) @(negedge clk_sys);
		i_host.rd(8'h00, rdat, ok);
		chk("ack", 8'h00, {7'h0, ok});
		chk("sda_out", 8'h00, {7'h0, sda_out});
		@(negedge clk_sys) module_select_n = 1'b0;
		repeat (10) @(negedge clk_sys);
		rd_chk(8'h00, 8'h3c);
		pin_reset(100);
		chk("fully_functional", 8'h01, {7'h0, fully_functional});
		pin_reset(210);
		chk("fully_functional", 8'h00, {7'h0, fully_functional});
		wait_ready();
		wait_int(1'b0);
		results();
	end
endmodule
